// ==== hdl/scr_pkg.sv ====
// Constants and types shared by the serial port control register block.
// Assumes a single 50 MHz system clock and a plain register port.
package scr_pkg;

  // --------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------
  localparam logic [3:0] ADDR_SERIAL_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_MODE_REG = 4'h1;
  localparam logic [3:0] ADDR_STATUS_REG = 4'h2;

  localparam logic [7:0] RST_SERIAL_CONTROL = 8'h00;
  localparam logic [7:0] RST_MODE_REG = 8'h00;

  // --------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------
  localparam int BIT_TX_EMPTY_IRQ_ON = 7;
  localparam int BIT_RX_IRQ_ON = 6;
  localparam int BIT_TX_ON = 5;
  localparam int BIT_RX_ON = 4;
  localparam int BIT_ADDR_WAIT_ON = 3;
  localparam int BIT_TX_DONE_IRQ_ON = 2;
  localparam int BIT_CLK_SRC_SEL_HI = 1;
  localparam int BIT_CLK_SRC_SEL_LO = 0;

  localparam int BIT_MODE_SYNC = 7;
  localparam int BIT_MULTIDROP_MODE = 2;

  localparam int BIT_TX_BUF_EMPTY = 7;
  localparam int BIT_RX_BUF_FULL = 6;
  localparam int BIT_OVERRUN_ERR = 5;
  localparam int BIT_FRAME_ERR = 4;
  localparam int BIT_TX_COMPLETE = 2;

  // --------------------------------------------------------------------
  // Clock-select codes
  // --------------------------------------------------------------------
  localparam logic [1:0] CKSEL_INT = 2'h0;
  localparam logic [1:0] CKSEL_INT_OUT = 2'h1;
  localparam logic [1:0] CKSEL_EXT = 2'h2;

  typedef enum logic [1:0] {
    SCR_CLK_BAUD,
    SCR_CLK_BAUD_OUT,
    SCR_CLK_EXT,
    SCR_CLK_NONE
  } scr_clk_e;

endpackage : scr_pkg

// ==== hdl/scr_sync3.sv ====
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to i_clk_sys.
`timescale 1ns/10ps
`default_nettype none
module scr_sync3 (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_async,
  output logic o_level
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic lvl_ff;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= i_async;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A change counts once stages two and three agree.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      lvl_ff <= 1'b0;
    end else if (s2_ff == s3_ff) begin
      lvl_ff <= s3_ff;
    end
  end

  assign o_level = lvl_ff;

endmodule : scr_sync3
`default_nettype wire

// ==== hdl/scr_gate.sv ====
// One interrupt request gate: a source request qualified by an enable.
// Assumes both inputs are on i_clk_sys.
`timescale 1ns/10ps
`default_nettype none
module scr_gate (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_req,
  input wire logic i_en,
  output logic o_irq
);

  logic irq_ff;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= i_req & i_en;
    end
  end

  assign o_irq = irq_ff;

endmodule : scr_gate
`default_nettype wire

// ==== hdl/scr_serial_control.sv ====
// Serial port control register with enables, request gating, address
// wait handling and serial clock pin selection.
// Assumes the shifters and baud generator sit outside and talk through
// the event and enable ports; the serial clock pin is three signals.
`timescale 1ns/10ps
`default_nettype none
module scr_serial_control (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Register port.
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Status sources from the shifters.
  input wire logic i_tx_load,
  input wire logic i_tx_last_bit,
  input wire logic i_tdr_write,
  input wire logic i_rx_done,
  input wire logic i_rx_mpb,
  input wire logic i_rx_frame_bad,
  input wire logic i_rdr_read,
  // Clocks from the baud generator.
  input wire logic i_baud_bit_clk,
  input wire logic i_baud_clk,
  // Serial clock pin.
  input wire logic i_serial_clk_pin,
  output logic o_serial_clk_pin,
  output logic o_serial_clk_pin_oe,
  // Enables and clock toward the shifters.
  output logic o_tx_on,
  output logic o_rx_on,
  output logic o_rx_accept,
  output logic o_sync_mode,
  output logic [1:0] o_clk_src,
  output logic o_shift_clk,
  // Interrupt requests.
  output logic o_tx_empty_irq,
  output logic o_rx_full_irq,
  output logic o_rx_error_irq,
  output logic o_tx_done_irq
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0] serial_control_ff;
  logic [7:0] mode_reg_ff;
  logic tx_buf_empty_ff;
  logic tx_complete_ff;
  logic rx_buf_full_ff;
  logic frame_err_ff;
  logic overrun_err_ff;
  logic [7:0] rdata_ff;
  logic [1:0] clk_src_ff;
  logic shift_clk_ff;
  logic pin_out_ff;
  logic pin_oe_ff;
  logic tx_on_ff;
  logic rx_on_ff;
  logic accept_ff;
  logic sync_mode_ff;
  logic pin_level;

  logic tx_on;
  logic rx_on;
  logic sync_mode;
  logic multidrop;
  logic wait_active;
  logic rx_take;
  logic wr_ctl;
  logic wr_status;
  logic [7:0] status_view;
  scr_pkg::scr_clk_e clk_mode;

  assign tx_on = serial_control_ff[scr_pkg::BIT_TX_ON];
  assign rx_on = serial_control_ff[scr_pkg::BIT_RX_ON];
  assign sync_mode = mode_reg_ff[scr_pkg::BIT_MODE_SYNC];
  assign multidrop = mode_reg_ff[scr_pkg::BIT_MULTIDROP_MODE];
  assign wr_ctl = i_wr && (i_addr == scr_pkg::ADDR_SERIAL_CONTROL);
  assign wr_status = i_wr && (i_addr == scr_pkg::ADDR_STATUS_REG);

  // Address wait counts only in asynchronous multidrop mode.
  assign wait_active = serial_control_ff[scr_pkg::BIT_ADDR_WAIT_ON] && multidrop
    && !sync_mode;
  // A received character is taken while rx is on, unless waiting and its mpb is zero.
  assign rx_take = i_rx_done && rx_on && !(wait_active && !i_rx_mpb);

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      serial_control_ff <= scr_pkg::RST_SERIAL_CONTROL;
    end else begin
      if (wr_ctl) begin
        serial_control_ff <= i_wdata;
      end
      // Hardware clear on an address character wins over a write.
      if (i_rx_done && rx_on && wait_active && i_rx_mpb) begin
        serial_control_ff[scr_pkg::BIT_ADDR_WAIT_ON] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      mode_reg_ff <= scr_pkg::RST_MODE_REG;
    end else if (i_wr && (i_addr == scr_pkg::ADDR_MODE_REG)) begin
      mode_reg_ff <= i_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Status flags: set wins over a software clear
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      tx_buf_empty_ff <= 1'b1;
      tx_complete_ff <= 1'b1;
    end else if (!tx_on) begin
      tx_buf_empty_ff <= 1'b1;
      tx_complete_ff <= 1'b1;
    end else begin
      if (i_tx_load) begin
        tx_buf_empty_ff <= 1'b1;
      end else if (i_tdr_write || (wr_status && !i_wdata[scr_pkg::BIT_TX_BUF_EMPTY])) begin
        tx_buf_empty_ff <= 1'b0;
      end
      if (i_tx_last_bit && tx_buf_empty_ff) begin
        tx_complete_ff <= 1'b1;
      end else if (i_tdr_write || (wr_status && !i_wdata[scr_pkg::BIT_TX_BUF_EMPTY])) begin
        tx_complete_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rx_buf_full_ff <= 1'b0;
      frame_err_ff <= 1'b0;
      overrun_err_ff <= 1'b0;
    end else begin
      // Flags are not touched while a skipped character passes.
      if (rx_take && !i_rx_frame_bad && !rx_buf_full_ff) begin
        rx_buf_full_ff <= 1'b1;
      end else if (i_rdr_read || (wr_status && !i_wdata[scr_pkg::BIT_RX_BUF_FULL])) begin
        rx_buf_full_ff <= 1'b0;
      end
      if (rx_take && i_rx_frame_bad) begin
        frame_err_ff <= 1'b1;
      end else if (wr_status && !i_wdata[scr_pkg::BIT_FRAME_ERR]) begin
        frame_err_ff <= 1'b0;
      end
      if (rx_take && rx_buf_full_ff) begin
        overrun_err_ff <= 1'b1;
      end else if (wr_status && !i_wdata[scr_pkg::BIT_OVERRUN_ERR]) begin
        overrun_err_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    status_view = 8'h00;
    status_view[scr_pkg::BIT_TX_BUF_EMPTY] = tx_buf_empty_ff;
    status_view[scr_pkg::BIT_RX_BUF_FULL] = rx_buf_full_ff;
    status_view[scr_pkg::BIT_OVERRUN_ERR] = overrun_err_ff;
    status_view[scr_pkg::BIT_FRAME_ERR] = frame_err_ff;
    status_view[scr_pkg::BIT_TX_COMPLETE] = tx_complete_ff;
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rdata_ff <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        scr_pkg::ADDR_SERIAL_CONTROL: rdata_ff <= serial_control_ff;
        scr_pkg::ADDR_MODE_REG: rdata_ff <= mode_reg_ff;
        scr_pkg::ADDR_STATUS_REG: rdata_ff <= status_view;
        default: rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------------
  always_comb begin
    clk_mode = scr_pkg::SCR_CLK_NONE;
    if (!sync_mode) begin
      unique case (serial_control_ff[1:0])
        scr_pkg::CKSEL_INT: clk_mode = scr_pkg::SCR_CLK_BAUD;
        scr_pkg::CKSEL_INT_OUT: clk_mode = scr_pkg::SCR_CLK_BAUD_OUT;
        scr_pkg::CKSEL_EXT: clk_mode = scr_pkg::SCR_CLK_EXT;
        default: clk_mode = scr_pkg::SCR_CLK_NONE;
      endcase
    end else begin
      unique case (serial_control_ff[1:0])
        scr_pkg::CKSEL_INT: clk_mode = scr_pkg::SCR_CLK_BAUD_OUT;
        scr_pkg::CKSEL_EXT: clk_mode = scr_pkg::SCR_CLK_EXT;
        default: clk_mode = scr_pkg::SCR_CLK_NONE;
      endcase
    end
  end

  scr_sync3 u_pin_sync (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_async(i_serial_clk_pin),
    .o_level(pin_level)
  );

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      clk_src_ff <= 2'h0;
      shift_clk_ff <= 1'b0;
      pin_out_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
    end else begin
      clk_src_ff <= clk_mode;
      pin_oe_ff <= (clk_mode == scr_pkg::SCR_CLK_BAUD_OUT);
      pin_out_ff <= (clk_mode == scr_pkg::SCR_CLK_BAUD_OUT) ? i_baud_bit_clk : 1'b0;
      unique case (clk_mode)
        scr_pkg::SCR_CLK_BAUD: shift_clk_ff <= i_baud_clk;
        scr_pkg::SCR_CLK_BAUD_OUT: shift_clk_ff <= sync_mode ? i_baud_bit_clk : i_baud_clk;
        scr_pkg::SCR_CLK_EXT: shift_clk_ff <= pin_level;
        scr_pkg::SCR_CLK_NONE: shift_clk_ff <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Enables toward the shifters
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      tx_on_ff <= 1'b0;
      rx_on_ff <= 1'b0;
      accept_ff <= 1'b0;
      sync_mode_ff <= 1'b0;
    end else begin
      tx_on_ff <= tx_on;
      rx_on_ff <= rx_on;
      accept_ff <= rx_on && !wait_active;
      sync_mode_ff <= sync_mode;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt request gates
  // ----------------------------------------------------------------------
  scr_gate u_txi (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_req(tx_buf_empty_ff),
    .i_en(serial_control_ff[scr_pkg::BIT_TX_EMPTY_IRQ_ON]),
    .o_irq(o_tx_empty_irq)
  );

  scr_gate u_rxi (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_req(rx_buf_full_ff),
    .i_en(serial_control_ff[scr_pkg::BIT_RX_IRQ_ON]),
    .o_irq(o_rx_full_irq)
  );

  scr_gate u_eri (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_req(frame_err_ff | overrun_err_ff),
    .i_en(serial_control_ff[scr_pkg::BIT_RX_IRQ_ON]),
    .o_irq(o_rx_error_irq)
  );

  scr_gate u_tei (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_req(tx_complete_ff),
    .i_en(serial_control_ff[scr_pkg::BIT_TX_DONE_IRQ_ON]),
    .o_irq(o_tx_done_irq)
  );

  assign o_rdata = rdata_ff;
  assign o_tx_on = tx_on_ff;
  assign o_rx_on = rx_on_ff;
  assign o_rx_accept = accept_ff;
  assign o_sync_mode = sync_mode_ff;
  assign o_clk_src = clk_src_ff;
  assign o_shift_clk = shift_clk_ff;
  assign o_serial_clk_pin = pin_out_ff;
  assign o_serial_clk_pin_oe = pin_oe_ff;

endmodule : scr_serial_control
`default_nettype wire

// ==== tb/scr_serial_control_assertions.sv ====
// Port checker for the serial control register block.
// Assumes one clock, synchronous active-high reset, bound to the top.
`timescale 1ns/10ps
`default_nettype none
module scr_serial_control_assertions (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_tx_on,
  input wire logic o_rx_on,
  input wire logic o_rx_accept,
  input wire logic o_sync_mode,
  input wire logic [1:0] o_clk_src,
  input wire logic o_serial_clk_pin_oe,
  input wire logic o_tx_empty_irq,
  input wire logic o_rx_full_irq,
  input wire logic o_rx_error_irq,
  input wire logic o_tx_done_irq
);
  // ------------------------------------------------------------------
  // Software copy of the enable bits
  // ------------------------------------------------------------------
  logic [7:0] ctl_ff;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ctl_ff <= 8'h00;
    end else if (i_wr && i_addr == scr_pkg::ADDR_SERIAL_CONTROL) begin
      ctl_ff <= i_wdata;
    end
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not idle");
  tx_en_a: assert property (i_wr && i_addr == scr_pkg::ADDR_SERIAL_CONTROL
    |-> ##2 o_tx_on == $past(i_wdata[5], 2)) else $error("tx enable wrong");
  rx_en_a: assert property (i_wr && i_addr == scr_pkg::ADDR_SERIAL_CONTROL
    |-> ##2 o_rx_on == $past(i_wdata[4], 2)) else $error("rx enable wrong");
  tx_gate_a: assert property (o_tx_empty_irq |-> $past(ctl_ff[7]))
    else $error("tx empty irq ungated");
  rx_gate_a: assert property ((o_rx_full_irq || o_rx_error_irq) |-> $past(ctl_ff[6]))
    else $error("rx irq ungated");
  done_gate_a: assert property (o_tx_done_irq |-> $past(ctl_ff[2]))
    else $error("tx done irq ungated");
  tx_off_a: assert property ((ctl_ff[7] && !ctl_ff[5] && ctl_ff[2])[*4]
    |-> o_tx_empty_irq && o_tx_done_irq) else $error("tx off flags not held");
  rx_accept_a: assert property (o_rx_accept |-> $past(ctl_ff[4]))
    else $error("accept without rx enable");
  pin_drive_a: assert property (o_serial_clk_pin_oe ==
    (o_clk_src == scr_pkg::SCR_CLK_BAUD_OUT)) else $error("pin driven wrongly");
  pin_input_a: assert property (o_clk_src == scr_pkg::CKSEL_EXT
    |-> !o_serial_clk_pin_oe) else $error("pin driven in external mode");

  tx_irq_c: cover property (o_tx_empty_irq);
  rx_irq_c: cover property (o_rx_error_irq);
  pin_oe_c: cover property (o_serial_clk_pin_oe);
endmodule : scr_serial_control_assertions

bind scr_serial_control scr_serial_control_assertions scr_serial_control_assertions_inst (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_tx_on(o_tx_on), .o_rx_on(o_rx_on),
  .o_rx_accept(o_rx_accept), .o_sync_mode(o_sync_mode), .o_clk_src(o_clk_src),
  .o_serial_clk_pin_oe(o_serial_clk_pin_oe), .o_tx_empty_irq(o_tx_empty_irq),
  .o_rx_full_irq(o_rx_full_irq), .o_rx_error_irq(o_rx_error_irq),
  .o_tx_done_irq(o_tx_done_irq));
`default_nettype wire

// ==== tb/scr_far_end.sv ====
// Far-side model: baud clocks and an external serial clock source.
// Assumes the bench resolves the shared pin from both drive enables.
`timescale 1ns/10ps
`default_nettype none
module scr_far_end #(
  parameter int EXT_HALF = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_ext_on,
  output logic o_baud_clk,
  output logic o_baud_bit_clk,
  output logic o_ext_clk
);
  int cnt = 0;
  initial begin
    o_baud_clk = 1'b0;
    o_baud_bit_clk = 1'b0;
    o_ext_clk = 1'b0;
  end
  // The bit clock runs sixteen times slower than the fast baud clock.
  always @(posedge i_clk_sys) begin
    cnt <= cnt + 1;
    o_baud_clk <= cnt[0];
    o_baud_bit_clk <= cnt[4];
    if (!i_ext_on) begin
      o_ext_clk <= 1'b0;
    end else if (cnt % EXT_HALF == 0) begin
      o_ext_clk <= !o_ext_clk;
    end
  end
endmodule : scr_far_end
`default_nettype wire

// ==== tb/scr_serial_control_test.sv ====
// Self-checking bench for the serial control register block.
// Assumes a pull-up on the serial clock pin when nobody drives it.
`timescale 1ns/10ps
`default_nettype none
module scr_serial_control_test;
  logic i_clk_sys = 1'b0;
  logic i_srst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [4:0] ev = 5'h00;
  logic mpb = 1'b0;
  logic fbad = 1'b0;
  logic ext_on = 1'b0;
  logic pin_w, baud_clk, bit_clk, ext_clk, pin_o, pin_oe, tx_on, rx_on, rx_acc, sync_m, sclk;
  logic [1:0] clk_src;
  logic [3:0] irq;
  logic [7:0] rdata;
  logic [7:0] md [6] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h80, 8'h80};
  logic [1:0] cd [6] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h2};
  logic [7:0] ex [6] = '{8'h00, 8'h03, 8'h04, 8'h00, 8'h0b, 8'h0c};
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int t;

  always #10 i_clk_sys = ~i_clk_sys;
  assign pin_w = pin_oe ? pin_o : (ext_on ? ext_clk : 1'b1);

  scr_far_end scr_far_end_inst (.i_clk_sys(i_clk_sys), .i_ext_on(ext_on),
    .o_baud_clk(baud_clk), .o_baud_bit_clk(bit_clk), .o_ext_clk(ext_clk));
  scr_serial_control scr_serial_control_inst (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
    .i_tx_load(ev[0]), .i_tx_last_bit(ev[1]), .i_tdr_write(ev[2]), .i_rx_done(ev[3]),
    .i_rx_mpb(mpb), .i_rx_frame_bad(fbad), .i_rdr_read(ev[4]), .i_baud_bit_clk(bit_clk),
    .i_baud_clk(baud_clk), .i_serial_clk_pin(pin_w), .o_serial_clk_pin(pin_o),
    .o_serial_clk_pin_oe(pin_oe), .o_tx_on(tx_on), .o_rx_on(rx_on), .o_rx_accept(rx_acc),
    .o_sync_mode(sync_m), .o_clk_src(clk_src), .o_shift_clk(sclk),
    .o_tx_empty_irq(irq[3]), .o_rx_full_irq(irq[2]), .o_rx_error_irq(irq[1]),
    .o_tx_done_irq(irq[0]));

  // ------------------------------------------------------------------
  // Access and check tasks
  // ------------------------------------------------------------------
  task chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %0t saw %h want %h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd
  task w;
    repeat (3) @(posedge i_clk_sys);
    #1;
  endtask : w
  task pulse(input logic [4:0] m);
    @(posedge i_clk_sys);
    ev <= m;
    @(posedge i_clk_sys);
    ev <= 5'h00;
    w;
  endtask : pulse
  task toggles(input logic sel, output int n);
    logic p;
    n = 0;
    p = sel ? sclk : pin_w;
    repeat (96) begin
      @(posedge i_clk_sys);
      if ((sel ? sclk : pin_w) !== p) n++;
      p = sel ? sclk : pin_w;
    end
  endtask : toggles
  task stop_test;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      stop_test;
    end
  end

  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'h2, 8'h84);
    rd(4'hf, 8'h00);
    wr(4'h0, 8'hf4);
    rd(4'h0, 8'hf4);
    w;
    chk({6'h00, tx_on, rx_on}, 8'h03);
    chk({4'h0, irq}, 8'h09);
    pulse(5'h04);
    chk({4'h0, irq}, 8'h00);
    pulse(5'h01);
    chk({4'h0, irq}, 8'h08);
    pulse(5'h02);
    chk({4'h0, irq}, 8'h09);
    wr(4'h0, 8'h34);
    pulse(5'h08);
    chk({4'h0, irq}, 8'h01);
    rd(4'h2, 8'hc4);
    wr(4'h0, 8'h74);
    w;
    chk({4'h0, irq}, 8'h05);
    fbad <= 1'b1;
    pulse(5'h08);
    chk({4'h0, irq}, 8'h07);
    rd(4'h2, 8'hf4);
    fbad <= 1'b0;
    wr(4'h2, 8'h84);
    wr(4'h0, 8'h84);
    pulse(5'h04);
    chk({4'h0, irq}, 8'h09);
    wr(4'h1, 8'h04);
    wr(4'h0, 8'h58);
    pulse(5'h08);
    fbad <= 1'b1;
    pulse(5'h08);
    chk({3'h0, rx_acc, irq}, 8'h00);
    rd(4'h2, 8'h84);
    rd(4'h0, 8'h58);
    fbad <= 1'b0;
    mpb <= 1'b1;
    pulse(5'h08);
    rd(4'h0, 8'h50);
    chk({3'h0, rx_acc, irq}, 8'h14);
    pulse(5'h10);
    mpb <= 1'b0;
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h58);
    pulse(5'h08);
    rd(4'h2, 8'hc4);
    rd(4'h0, 8'h58);
    wr(4'h2, 8'h84);
    wr(4'h0, 8'h40);
    pulse(5'h08);
    rd(4'h2, 8'h84);
    for (int i = 0; i < 6; i++) begin
      ext_on <= (cd[i] == 2'h2);
      wr(4'h1, md[i]);
      wr(4'h0, {6'h00, cd[i]});
      w;
      chk({4'h0, sync_m, clk_src, pin_oe}, ex[i]);
      if (ex[i][0]) begin
        toggles(1'b0, t);
        chk({7'h00, t > 0}, 8'h01);
      end
      if (cd[i] == 2'h2) begin
        toggles(1'b1, t);
        chk({7'h00, t > 0}, 8'h01);
      end
    end
    stop_test;
  end
endmodule : scr_serial_control_test
`default_nettype wire
